/* File: mst_params.svh */
// constants for the memory self-test controller and dispatch unit
`ifndef MST_PARAMS_SVH
`define MST_PARAMS_SVH
`define MST_NCORE 4
`define MST_ADDR_W 12
`define MST_DATA_W 32
`define MST_CIR_W 18
`define MST_DIR_W 38
`define MST_TX_W 12
`define MST_RX_W 6
`define MST_RES_W 6
`define MST_READ_LAT 1
`define MST_DRAIN_CYC 3'h3
// controller-to-dispatch bus bit positions
`define MST_TX_STALL 11
`define MST_TX_PRESET 10
`define MST_TX_LOGSH 9
`define MST_TX_DIR 7
`define MST_TX_READ 6
`define MST_TX_WRITE 5
`define MST_TX_CKBD 4
`define MST_TX_DATA 3
`define MST_TX_STEP 1
`define MST_TX_SHIFT 0
// dispatch-to-controller bus bit positions
`define MST_RX_EXPIRED 4
`define MST_RX_CHAIN 5
// result bus bit positions
`define MST_RES_FAIL 1
`define MST_RES_FINISH 0
// controller instruction fields
`define MST_CIR_FULL 0
`define MST_CIR_INV 1
`define MST_CIR_CKBD 2
`define MST_CIR_DOWN 3
// dispatch instruction fields
`define MST_DIR_LAST_LSB 0
`define MST_DIR_SEED_LSB 12
`define MST_SEED_W 26
`define MST_CKBD_MASK 32'h55555555
// register map and control register pause bit
`define MST_OFS_CTRL 12'h000
`define MST_OFS_STATUS 12'h004
`define MST_OFS_FAILCNT 12'h008
`define MST_CTRL_PAUSE 0
`endif

/* File: mst_pkg.sv */
// types shared by the memory self-test controller and dispatch unit
`include "mst_params.svh"
package mst_pkg;
  typedef enum logic [2:0] {
    st_idle, st_shift, st_preset, st_run, st_stall, st_drain, st_done
  } mst_state_type;

  typedef struct packed {
    mst_state_type st;
    mst_state_type ret;
    logic [`MST_CIR_W-1:0] ir;
    logic [1:0] elem;
    logic [2:0] drain;
    logic dshift_seen;
    logic finish;
    logic fail;
    logic [15:0] fail_cnt;
    logic pause;
    logic sel;
    logic [31:0] prdata;
    logic pslverr;
    logic [`MST_RES_W-1:0] result;
  } mst_ctrl_state_type;

  typedef struct packed {
    logic [`MST_DIR_W-1:0] ir;
    logic [`MST_ADDR_W-1:0] ac;
    logic [`MST_ADDR_W-1:0] addr;
    logic [`MST_DATA_W-1:0] wdata;
    logic we;
    logic re;
    logic [`MST_READ_LAT:0] pv;
    logic [`MST_READ_LAT:0][`MST_DATA_W-1:0] pexp;
    logic [`MST_READ_LAT:0][`MST_ADDR_W-1:0] paddr;
    logic [`MST_NCORE-1:0][`MST_ADDR_W-1:0] flog;
  } mst_disp_state_type;
endpackage

/* File: mst_dispatch.sv */
// dispatch unit: ram access, address generation, scrambling and compare
`timescale 1ns/1ps
`include "mst_params.svh"
module mst_dispatch (
  input wire logic i_mclk, // system clock
  input wire logic i_nrst, // async reset, active low
  input wire logic [`MST_TX_W-1:0] i_tx, // controller-to-dispatch bus
  output logic [`MST_RX_W-1:0] o_rx, // dispatch-to-controller bus
  input wire logic [`MST_NCORE-1:0] i_core_present, // cores under test
  output logic [`MST_ADDR_W-1:0] o_ram_addr, // physical ram address
  output logic [`MST_DATA_W-1:0] o_ram_wdata, // ram write data
  output logic o_we, // ram write enable
  output logic o_re, // ram read enable
  input wire logic [`MST_NCORE-1:0][`MST_DATA_W-1:0] i_ram_rdata // read data per core
);
  import mst_pkg::*;

  mst_disp_state_type s;
  mst_disp_state_type n;
  logic [`MST_NCORE-1:0] fail;
  logic [`MST_ADDR_W-1:0] last;
  logic [`MST_ADDR_W-1:0] end_addr;
  logic [`MST_SEED_W-1:0] seed;

  // logical to physical map; replace per ram layout so neighbours follow in turn
  function automatic logic [`MST_ADDR_W-1:0] scramble(input logic [`MST_ADDR_W-1:0] a);
    scramble = {a[`MST_ADDR_W-1:1], a[1] ^ a[0]};
  endfunction

  // expected data for a logical address under current bus controls
  function automatic logic [`MST_DATA_W-1:0] pattern(input logic [`MST_ADDR_W-1:0] a,
                                                     input logic inv, input logic ckbd);
    pattern = {seed[5:0], seed};
    if (inv)
      pattern = ~pattern;
    if (ckbd && a[0])
      pattern = pattern ^ `MST_CKBD_MASK;
  endfunction

  assign last = s.ir[`MST_DIR_LAST_LSB +: `MST_ADDR_W];
  assign seed = s.ir[`MST_DIR_SEED_LSB +: `MST_SEED_W];
  assign end_addr = i_tx[`MST_TX_DIR] ? '0 : last;

  // compare at the stage aligned with the core read latency
  genvar c;
  generate
    for (c = 0; c < `MST_NCORE; c++) begin : g_cmp
      assign fail[c] = s.pv[`MST_READ_LAT] && i_core_present[c] &&
                       (i_ram_rdata[c] != s.pexp[`MST_READ_LAT]);
      // log bit shifted out in place of the fail pulse
      assign o_rx[c] = i_tx[`MST_TX_LOGSH] ? s.flog[c][`MST_ADDR_W-1] : fail[c];
    end
  endgenerate

  assign o_rx[`MST_RX_EXPIRED] = (s.ac == end_addr);
  assign o_rx[`MST_RX_CHAIN] = s.ir[`MST_DIR_W-1];

  // next state
  always_comb begin
    n = s;
    if (i_tx[`MST_TX_SHIFT])
      n.ir = {s.ir[`MST_DIR_W-2:0], i_tx[`MST_TX_DATA]};
    if (i_tx[`MST_TX_PRESET])
      n.ac = i_tx[`MST_TX_DIR] ? last : '0;
    n.we = 1'b0;
    n.re = 1'b0;
    n.pv[0] = 1'b0;
    n.pexp[0] = pattern(s.ac, i_tx[`MST_TX_DATA], i_tx[`MST_TX_CKBD]);
    n.paddr[0] = s.ac;
    // stall freezes issue and stepping, the compare pipe still drains
    if (!i_tx[`MST_TX_STALL] && !i_tx[`MST_TX_SHIFT]) begin
      if (i_tx[`MST_TX_WRITE] || i_tx[`MST_TX_READ]) begin
        n.addr = scramble(s.ac);
        n.wdata = n.pexp[0];
        n.we = i_tx[`MST_TX_WRITE];
        n.re = i_tx[`MST_TX_READ] && !i_tx[`MST_TX_WRITE];
        n.pv[0] = n.re;
      end
      if (i_tx[`MST_TX_STEP])
        n.ac = i_tx[`MST_TX_DIR] ? s.ac - 1'b1 : s.ac + 1'b1;
    end
    for (int k = 1; k <= `MST_READ_LAT; k++) begin
      n.pv[k] = s.pv[k-1];
      n.pexp[k] = s.pexp[k-1];
      n.paddr[k] = s.paddr[k-1];
    end
    // failing address capture, or serial log shift-out
    for (int j = 0; j < `MST_NCORE; j++) begin
      if (i_tx[`MST_TX_LOGSH])
        n.flog[j] = {s.flog[j][`MST_ADDR_W-2:0], 1'b0};
      else if (fail[j])
        n.flog[j] = s.paddr[`MST_READ_LAT];
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst)
      s <= '0;
    else
      s <= n;
  end

  assign o_ram_addr = s.addr;
  assign o_ram_wdata = s.wdata;
  assign o_we = s.we;
  assign o_re = s.re;
endmodule

/* File: mst_self_test.sv */
// memory self-test controller top: tester port, sequencer, apb status
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "mst_params.svh"
module mst_self_test (
  input wire logic i_mclk, // system clock, 25 MHz
  input wire logic i_nrst, // async reset, active low
  // apb slave
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error
  // tester port
  input wire logic i_ram_test_mode_select, // grants rams to the test port
  input wire logic i_instr_shift_enable, // serial instruction load
  input wire logic i_instr_serial_in, // serial instruction data
  input wire logic i_test_run_enable, // run loaded instruction
  input wire logic i_faillog_shift_enable, // shift out fail log
  output logic [`MST_RES_W-1:0] o_test_result_bus, // result and status
  // ram side
  input wire logic [`MST_NCORE-1:0] i_core_present, // cores to compare
  output logic o_ram_test_select, // core mux select to test port
  output logic [`MST_ADDR_W-1:0] o_ram_addr, // physical ram address
  output logic [`MST_DATA_W-1:0] o_ram_wdata, // ram write data
  output logic o_test_ram_write_enable, // ram write enable
  output logic o_ram_read_enable, // ram read enable
  input wire logic [`MST_NCORE-1:0][`MST_DATA_W-1:0] i_ram_rdata // read data per core
);
  import mst_pkg::*;

  mst_ctrl_state_type s;
  mst_ctrl_state_type n;
  logic [`MST_TX_W-1:0] ctrl_to_dispatch_bus;
  logic [`MST_RX_W-1:0] dispatch_to_ctrl_bus;
  logic active;
  logic fail_evt;
  logic wr_elem;
  logic last_elem;

  // register decode for the error answer; the read mux decodes on its own
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `MST_OFS_CTRL) || (a == `MST_OFS_STATUS) || (a == `MST_OFS_FAILCNT);
  endfunction

  function automatic logic [31:0] rd_mux(input logic [11:0] a, input mst_ctrl_state_type q);
    rd_mux = '0;
    if (a == `MST_OFS_CTRL)
      rd_mux[`MST_CTRL_PAUSE] = q.pause;
    else if (a == `MST_OFS_STATUS)
      rd_mux = {22'h000000, q.elem, 3'(q.st), q.sel, 2'h0, q.fail, q.finish};
    else if (a == `MST_OFS_FAILCNT)
      rd_mux = {16'h0000, q.fail_cnt};
  endfunction

  // test runs only with the rams granted and run held high
  assign active = i_ram_test_mode_select && i_test_run_enable;
  // even elements write, odd elements read
  assign wr_elem = !s.elem[0];
  assign last_elem = s.ir[`MST_CIR_FULL] ? (s.elem == 2'h3) : (s.elem == 2'h1);
  // log shift turns the fail pulses into log bits, so they are no events then
  assign fail_evt = |dispatch_to_ctrl_bus[`MST_NCORE-1:0] && !ctrl_to_dispatch_bus[`MST_TX_LOGSH];

  // controller-to-dispatch bus, decoded from state and instruction
  always_comb begin
    ctrl_to_dispatch_bus = '0;
    // second half of a full march runs inverted data the other way
    ctrl_to_dispatch_bus[`MST_TX_DIR] = s.ir[`MST_CIR_DOWN] ^ s.elem[1];
    ctrl_to_dispatch_bus[`MST_TX_CKBD] = s.ir[`MST_CIR_CKBD];
    ctrl_to_dispatch_bus[`MST_TX_DATA] = s.ir[`MST_CIR_INV] ^ s.elem[1];
    unique case (s.st)
      st_idle, st_shift, st_done: begin
      end
      st_preset: begin
        ctrl_to_dispatch_bus[`MST_TX_PRESET] = 1'b1;
      end
      st_run: begin
        // no issue once the grant or run drops, even in the abort cycle
        if (s.pause || !active) begin
          ctrl_to_dispatch_bus[`MST_TX_STALL] = 1'b1;
        end else begin
          ctrl_to_dispatch_bus[`MST_TX_WRITE] = wr_elem;
          ctrl_to_dispatch_bus[`MST_TX_READ] = !wr_elem;
          ctrl_to_dispatch_bus[`MST_TX_STEP] = 1'b1;
        end
      end
      st_stall: begin
        ctrl_to_dispatch_bus[`MST_TX_STALL] = 1'b1;
        ctrl_to_dispatch_bus[`MST_TX_LOGSH] = i_faillog_shift_enable;
      end
      st_drain: begin
        ctrl_to_dispatch_bus[`MST_TX_STALL] = 1'b1;
      end
    endcase
    // shift overrides everything: the serial stream rides bit 3
    if (i_instr_shift_enable) begin
      ctrl_to_dispatch_bus = '0;
      ctrl_to_dispatch_bus[`MST_TX_SHIFT] = 1'b1;
      ctrl_to_dispatch_bus[`MST_TX_DATA] = i_instr_serial_in;
    end
  end

  // sequencer, status and register next state
  always_comb begin
    n = s;
    n.sel = i_ram_test_mode_select;
    unique case (s.st)
      st_idle: begin
      end
      st_shift: begin
        // armed: start as soon as the tester raises run
        if (active) begin
          n.st = st_preset;
          n.elem = 2'h0;
        end
      end
      st_preset: begin
        n.st = active ? st_run : st_idle;
      end
      st_run: begin
        if (!active) begin
          n.st = st_idle;
        end else if (!s.pause && dispatch_to_ctrl_bus[`MST_RX_EXPIRED]) begin
          // last address of this element was just issued
          if (last_elem) begin
            n.st = st_drain;
            n.drain = `MST_DRAIN_CYC;
          end else begin
            n.st = st_preset;
            n.elem = s.elem + 2'h1;
          end
        end
      end
      st_stall: begin
        if (i_faillog_shift_enable)
          n.dshift_seen = 1'b1;
        if (s.dshift_seen && !i_faillog_shift_enable)
          n.st = s.ret;
      end
      st_drain: begin
        // let the last reads reach the compare stage
        if (s.drain == 3'h0) begin
          n.st = st_done;
          n.finish = 1'b1;
        end else begin
          n.drain = s.drain - 3'h1;
        end
      end
      st_done: begin
      end
    endcase
    // a failing compare parks the sequencer for the log
    if (fail_evt && (s.st == st_run || s.st == st_preset || s.st == st_drain)) begin
      n.ret = n.st;
      n.st = st_stall;
      n.dshift_seen = 1'b0;
    end
    // new load clears results; a fail in the same cycle still counts
    if (i_instr_shift_enable) begin
      n.st = st_shift;
      n.ir = {s.ir[`MST_CIR_W-2:0], dispatch_to_ctrl_bus[`MST_RX_CHAIN]};
      n.finish = 1'b0;
      n.fail = 1'b0;
      n.fail_cnt = '0;
    end
    if (fail_evt) begin
      n.fail = 1'b1;
      if (n.fail_cnt != 16'hFFFF)
        n.fail_cnt = n.fail_cnt + 16'h0001;
    end
    // result bus: serial data in bits 5..2, registered
    if (i_instr_shift_enable)
      n.result[5:2] = {4{s.ir[`MST_CIR_W-1]}};
    else if (ctrl_to_dispatch_bus[`MST_TX_LOGSH])
      n.result[5:2] = dispatch_to_ctrl_bus[`MST_NCORE-1:0];
    else
      n.result[5:2] = {4{dispatch_to_ctrl_bus[`MST_RX_EXPIRED]}};
    n.result[`MST_RES_FAIL] = n.fail;
    n.result[`MST_RES_FINISH] = n.finish;
    // apb: data and error prepared in setup, shown during access
    n.prdata = '0;
    n.pslverr = 1'b0;
    if (i_psel && !i_penable) begin
      n.pslverr = !mapped(i_paddr);
      if (!i_pwrite)
        n.prdata = rd_mux(i_paddr, s);
    end
    if (i_psel && i_penable && i_pwrite && i_paddr == `MST_OFS_CTRL)
      n.pause = i_pwdata[`MST_CTRL_PAUSE];
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst)
      s <= '0;
    else
      s <= n;
  end

  // dispatch unit holds the other 38 instruction bits and the ram port
  mst_dispatch u_dispatch (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_tx(ctrl_to_dispatch_bus),
    .o_rx(dispatch_to_ctrl_bus),
    .i_core_present(i_core_present),
    .o_ram_addr(o_ram_addr),
    .o_ram_wdata(o_ram_wdata),
    .o_we(o_test_ram_write_enable),
    .o_re(o_ram_read_enable),
    .i_ram_rdata(i_ram_rdata)
  );

  // outputs straight from flops; apb always answers without wait
  assign o_ram_test_select = s.sel;
  assign o_test_result_bus = s.result;
  assign o_prdata = s.prdata;
  assign o_pslverr = s.pslverr;
  assign o_pready = 1'b1;
endmodule

/* File: mst_asserts.sv */
// concurrent checks on the memory self-test top ports
`timescale 1ns/1ps
`include "mst_params.svh"
module mst_chk (
  input wire logic i_mclk, // clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_ram_test_mode_select, // test grant
  input wire logic i_instr_shift_enable, // serial load
  input wire logic i_instr_serial_in, // serial bit
  input wire logic i_faillog_shift_enable, // log shift
  input wire logic [`MST_RES_W-1:0] o_test_result_bus, // result bus
  input wire logic o_ram_test_select, // mux select
  input wire logic o_test_ram_write_enable, // ram write
  input wire logic o_ram_read_enable // ram read
);
  logic [55:0] hist;
  logic [5:0] cnt;
  default clocking dc @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  // serial history predicts the bit leaving the chain; count saturates so old loads stay valid
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      hist <= '0;
      cnt <= 6'h00;
    end else if (i_instr_shift_enable) begin
      hist <= {hist[54:0], i_instr_serial_in};
      cnt <= (cnt == 6'h3F) ? cnt : cnt + 6'h01;
    end
  end
  mode_grant_a: assert property ($rose(i_ram_test_mode_select) |=> o_ram_test_select)
    else $error("mux not granted to test port");
  access_grant_a: assert property ((o_test_ram_write_enable || o_ram_read_enable) |-> o_ram_test_select)
    else $error("ram access without grant");
  chain_echo_a: assert property (i_instr_shift_enable && cnt >= 6'h38 |=> o_test_result_bus[5:2] == {4{$past(hist[55])}})
    else $error("old instruction bit not echoed");
  shift_idle_a: assert property (i_instr_shift_enable [*3] |-> !o_test_ram_write_enable && !o_ram_read_enable)
    else $error("ram access while loading");
  rw_exclusive_a: assert property (!(o_test_ram_write_enable && o_ram_read_enable))
    else $error("write and read together");
  fail_sticky_a: assert property (o_test_result_bus[1] && !i_instr_shift_enable |=> o_test_result_bus[1])
    else $error("fail flag dropped");
  stall_hold_a: assert property (o_test_result_bus[1] && i_faillog_shift_enable |=> !o_test_ram_write_enable && !o_ram_read_enable)
    else $error("access during fail stall");
  finish_hold_a: assert property (o_test_result_bus[0] && !i_instr_shift_enable |=> o_test_result_bus[0])
    else $error("finish dropped");
  shift_clear_a: assert property (i_instr_shift_enable |=> !o_test_result_bus[0])
    else $error("finish not cleared by load");
  // main scenarios reached
  cover property ($rose(o_test_result_bus[0]));
  cover property ($rose(o_test_result_bus[1]));
  cover property (o_test_ram_write_enable ##[1:20] o_ram_read_enable);
endmodule

bind mst_self_test mst_chk u_chk (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ram_test_mode_select(i_ram_test_mode_select),
  .i_instr_shift_enable(i_instr_shift_enable), .i_instr_serial_in(i_instr_serial_in),
  .i_faillog_shift_enable(i_faillog_shift_enable), .o_test_result_bus(o_test_result_bus),
  .o_ram_test_select(o_ram_test_select), .o_test_ram_write_enable(o_test_ram_write_enable),
  .o_ram_read_enable(o_ram_read_enable));

/* File: mst_ram_model.sv */
// behavioural ram behind the core muxes, four cores, per-core read corruption
`timescale 1ns/1ps
`include "mst_params.svh"
module mst_ram_model (
  input wire logic i_mclk, // clock
  input wire logic i_sel, // mux granted to test port
  input wire logic [`MST_ADDR_W-1:0] i_addr, // physical address
  input wire logic [`MST_DATA_W-1:0] i_wdata, // write data
  input wire logic i_we, // write enable
  input wire logic i_re, // read enable
  input wire logic [`MST_NCORE-1:0] i_flip, // cores returning corrupt data
  output logic [`MST_NCORE-1:0][`MST_DATA_W-1:0] o_rdata // read data per core
);
  logic [`MST_DATA_W-1:0] mem [0:4095];
  initial o_rdata = '0;
  // all cores share one size and contents; stale data toggles so it never looks valid
  always @(posedge i_mclk) begin
    for (int c = 0; c < `MST_NCORE; c++) begin
      if (i_sel && i_re) o_rdata[c] <= mem[i_addr] ^ {`MST_DATA_W{i_flip[c]}};
      else o_rdata[c] <= ~o_rdata[c];
    end
    if (i_sel && i_we) mem[i_addr] <= i_wdata;
  end
endmodule

/* File: testbench.sv */
// self-checking bench for the memory self-test controller
`timescale 1ns/1ps
`include "mst_params.svh"
module testbench;
  localparam logic [25:0] seed = 26'h1234567;
  localparam logic [31:0] base = {seed[5:0], seed};
  localparam logic [11:0] fail_addr = 12'h001;
  logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000, la;
  logic [31:0] pwdata = 32'h00000000, prdata, rd, wd;
  logic pready, pslverr, err, sel, we, re;
  logic mode = 1'b0, shift = 1'b0, sin = 1'b0, run = 1'b0, logsh = 1'b0;
  logic [`MST_RES_W-1:0] res;
  logic [`MST_NCORE-1:0] present = 4'hF, flip = 4'h0;
  logic [`MST_ADDR_W-1:0] addr;
  logic [`MST_DATA_W-1:0] wdata;
  logic [`MST_NCORE-1:0][`MST_DATA_W-1:0] rdata;
  logic [`MST_ADDR_W-1:0] waddr_q[$];
  logic [`MST_DATA_W-1:0] wdata_q[$];
  int miscompares = 0, samples_checked = 0, cycles = 0, nreads = 0;

  always #20 mclk = ~mclk;

  mst_self_test u_dut (.i_mclk(mclk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_ram_test_mode_select(mode), .i_instr_shift_enable(shift), .i_instr_serial_in(sin),
    .i_test_run_enable(run), .i_faillog_shift_enable(logsh), .o_test_result_bus(res),
    .i_core_present(present), .o_ram_test_select(sel), .o_ram_addr(addr), .o_ram_wdata(wdata),
    .o_test_ram_write_enable(we), .o_ram_read_enable(re), .i_ram_rdata(rdata));
  mst_ram_model u_ram (.i_mclk(mclk), .i_sel(sel), .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re),
    .i_flip(flip), .o_rdata(rdata));

  // ram traffic log and hang guard
  always @(posedge mclk) begin
    cycles++;
    if (we) begin
      waddr_q.push_back(addr);
      wdata_q.push_back(wdata);
    end
    if (re) nreads++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // 56-bit load, first bit lands in controller bit 17
  task automatic load(input logic [17:0] ci, input logic [11:0] last);
    logic [55:0] v;
    v = {ci, seed, last};
    for (int i = 55; i >= 0; i--) begin
      @(posedge mclk);
      shift <= 1'b1;
      sin <= v[i];
    end
    @(posedge mclk);
    shift <= 1'b0;
  endtask

  // run until finish or fail shows on the result bus
  task automatic go();
    @(posedge mclk);
    run <= 1'b1;
    @(posedge mclk);
    while (res[1:0] === 2'b00) @(posedge mclk);
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    apb(1'b0, 12'h004, 32'h00000000);
    check(rd, 32'h00000000, "status after reset");
    apb(1'b1, 12'h000, 32'h00000001);
    apb(1'b0, 12'h000, 32'h00000000);
    check(rd, 32'h00000001, "pause readback");
    apb(1'b1, 12'h000, 32'h00000000);
    apb(1'b0, 12'h00C, 32'h00000000);
    check({31'h0, err}, 32'h00000001, "unmapped error");
    $display("test registers done");
    // corrupt core left out of the compare must not fail the run
    mode <= 1'b1;
    present <= 4'hB;
    flip <= 4'h4;
    load(18'h00000, 12'h003);
    go();
    check({30'h0, res[1:0]}, 32'h00000001, "clean finish");
    check(32'(waddr_q.size()), 32'h00000004, "write count");
    check(32'(nreads), 32'h00000004, "read count");
    for (int i = 0; i < 4; i++) begin
      la = 12'(i);
      check({20'h0, waddr_q[i]}, {20'h0, la[11:1], la[1] ^ la[0]}, "write address");
      check(wdata_q[i], {seed[5:0], seed}, "write data");
    end
    apb(1'b0, 12'h004, 32'h00000000);
    check(rd & 32'h000000FF, 32'h000000D1, "status done");
    run <= 1'b0;
    repeat (2) @(posedge mclk);
    check({31'h0, res[0]}, 32'h00000001, "finish held");
    $display("test clean run done");
    // compare failure on both reads, stall, log shift, resume
    present <= 4'hF;
    load(18'h00000, 12'h001);
    check({30'h0, res[1:0]}, 32'h00000000, "load clears status");
    go();
    check({30'h0, res[1:0]}, 32'h00000002, "fail seen");
    flip <= 4'h0;
    apb(1'b0, 12'h008, 32'h00000000);
    check(rd, 32'h00000002, "fail count");
    apb(1'b0, 12'h004, 32'h00000000);
    check(rd & 32'h000000E0, 32'h00000080, "stalled");
    // last failing address comes out msb first, one cycle behind the shift
    @(posedge mclk);
    logsh <= 1'b1;
    @(posedge mclk);
    for (int b = 11; b >= 0; b--) begin
      @(posedge mclk);
      if (b == 1) logsh <= 1'b0;
      check({28'h0, res[5:2]}, {28'h0, 1'b0, fail_addr[b], 2'b00}, "fail log bit");
    end
    while (res[0] !== 1'b1) @(posedge mclk);
    check({30'h0, res[1:0]}, 32'h00000003, "resumed to finish");
    run <= 1'b0;
    $display("test fail run done");
    // full march with inverted data and checkerboard, held by pause first
    load(18'h00007, 12'h001);
    check({30'h0, res[1:0]}, 32'h00000000, "reload clears");
    $display("test reload done");
    waddr_q.delete();
    wdata_q.delete();
    nreads = 0;
    apb(1'b1, 12'h000, 32'h00000001);
    run <= 1'b1;
    repeat (8) @(posedge mclk);
    check(32'(waddr_q.size()), 32'h00000000, "no issue while paused");
    apb(1'b1, 12'h000, 32'h00000000);
    go();
    check({30'h0, res[1:0]}, 32'h00000001, "march finish");
    check(32'(waddr_q.size()), 32'h00000004, "march writes");
    check(32'(nreads), 32'h00000004, "march reads");
    for (int i = 0; i < 4; i++) begin
      la = (i == 1 || i == 2) ? 12'h001 : 12'h000;
      wd = (i < 2) ? ~base : base;
      if (la[0]) wd = wd ^ `MST_CKBD_MASK;
      check({20'h0, waddr_q[i]}, {20'h0, la}, "march address");
      check(wdata_q[i], wd, "march data");
    end
    $display("test march done");
    final_report();
  end

  task automatic final_report();
    $display("checked %0d, wrong %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
endmodule
